// *** rtl/alu_ops_pkg.sv ***
// Shared types and constants for the logic and shift execution datapath.
package alu_ops_pkg;

    // Operation kinds carried by a decoded opcode.
    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_AND = 3'b001,
        OP_ASL = 3'b010,
        OP_ASR = 3'b011,
        OP_SHIFT_LEFT_DOUBLE = 3'b100
    } op_kind_type;

    // Addressing modes; INH covers the accumulator and double forms.
    typedef enum logic [2:0] {
        MODE_INH = 3'b000,
        MODE_IMM = 3'b001,
        MODE_DIR = 3'b010,
        MODE_EXT = 3'b011,
        MODE_IDX = 3'b100
    } mode_type;

    // One decoded instruction.
    typedef struct packed {
        op_kind_type op;
        logic acc_b;
        mode_type mode;
    } decode_type;

    // Arithmetic flags that this datapath changes.
    typedef struct packed {
        logic n;
        logic z;
        logic v;
        logic c;
    } nzvc_type;

    // Datapath result with its flags.
    typedef struct packed {
        logic [15:0] res;
        nzvc_type f;
    } alu_out_type;

    // Opcodes.
    localparam logic [7:0] OPC_PREFIX_Y = 8'h18;
    localparam logic [7:0] OPC_AND_A_IMM = 8'h84;
    localparam logic [7:0] OPC_AND_A_DIR = 8'h94;
    localparam logic [7:0] OPC_AND_A_EXT = 8'hB4;
    localparam logic [7:0] OPC_AND_A_IDX = 8'hA4;
    localparam logic [7:0] OPC_AND_B_IMM = 8'hC4;
    localparam logic [7:0] OPC_AND_B_DIR = 8'hD4;
    localparam logic [7:0] OPC_AND_B_EXT = 8'hF4;
    localparam logic [7:0] OPC_AND_B_IDX = 8'hE4;
    localparam logic [7:0] OPC_ASL_A = 8'h48;
    localparam logic [7:0] OPC_ASL_B = 8'h58;
    localparam logic [7:0] OPC_ASL_EXT = 8'h78;
    localparam logic [7:0] OPC_ASL_IDX = 8'h68;
    localparam logic [7:0] OPC_ASR_A = 8'h47;
    localparam logic [7:0] OPC_ASR_B = 8'h57;
    localparam logic [7:0] OPC_ASR_EXT = 8'h77;
    localparam logic [7:0] OPC_ASR_IDX = 8'h67;
    localparam logic [7:0] OPC_SHIFT_LEFT_DOUBLE = 8'h05;

    // Bus constants.
    localparam logic [15:0] DUMMY_ADDR = 16'hFFFF;
    localparam logic [7:0] DIRECT_PAGE = 8'h00;

    // Flag positions in the condition flags register.
    localparam int FLAG_C = 0;
    localparam int FLAG_V = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_N = 3;

    // Register byte offsets on the Avalon slave.
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_PC = 4'h4;
    localparam logic [3:0] OFS_INDEX = 4'h8;
    localparam logic [3:0] OFS_ACC = 4'hC;

    // Control bit positions and reset values.
    localparam int CTRL_RUN = 0;
    localparam int CTRL_BUSY = 1;
    localparam logic CTRL_RUN_RESET = 1'b0;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [15:0] INDEX_RESET = 16'h0000;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [7:0] FLAGS_RESET = 8'h00;

endpackage

// *** rtl/op_decoder.sv ***
// Opcode decoder for the logic and shift instruction group.
`timescale 1ns/1ps
`default_nettype none
module op_decoder
    import alu_ops_pkg::*;
(
    // Opcode byte.
    input wire logic [7:0] opcode_in,
    // Decoded instruction.
    output var decode_type dec_out
);

    // Unknown opcodes decode to a one-byte operation with no effect.
    always_comb begin
        dec_out = '{op: OP_NONE, acc_b: 1'b0, mode: MODE_INH};
        case (opcode_in)
            OPC_AND_A_IMM: dec_out = '{OP_AND, 1'b0, MODE_IMM}; // RULE3
            OPC_AND_A_DIR: dec_out = '{OP_AND, 1'b0, MODE_DIR}; // RULE3
            OPC_AND_A_EXT: dec_out = '{OP_AND, 1'b0, MODE_EXT}; // RULE3
            OPC_AND_A_IDX: dec_out = '{OP_AND, 1'b0, MODE_IDX}; // RULE3
            OPC_AND_B_IMM: dec_out = '{OP_AND, 1'b1, MODE_IMM}; // RULE4
            OPC_AND_B_DIR: dec_out = '{OP_AND, 1'b1, MODE_DIR}; // RULE4
            OPC_AND_B_EXT: dec_out = '{OP_AND, 1'b1, MODE_EXT}; // RULE4
            OPC_AND_B_IDX: dec_out = '{OP_AND, 1'b1, MODE_IDX}; // RULE4
            OPC_ASL_A: dec_out = '{OP_ASL, 1'b0, MODE_INH}; // RULE7
            OPC_ASL_B: dec_out = '{OP_ASL, 1'b1, MODE_INH}; // RULE7
            OPC_ASL_EXT: dec_out = '{OP_ASL, 1'b0, MODE_EXT}; // RULE7
            OPC_ASL_IDX: dec_out = '{OP_ASL, 1'b0, MODE_IDX}; // RULE7
            OPC_ASR_A: dec_out = '{OP_ASR, 1'b0, MODE_INH}; // RULE14
            OPC_ASR_B: dec_out = '{OP_ASR, 1'b1, MODE_INH}; // RULE14
            OPC_ASR_EXT: dec_out = '{OP_ASR, 1'b0, MODE_EXT}; // RULE14
            OPC_ASR_IDX: dec_out = '{OP_ASR, 1'b0, MODE_IDX}; // RULE14
            OPC_SHIFT_LEFT_DOUBLE: dec_out = '{OP_SHIFT_LEFT_DOUBLE, 1'b0, MODE_INH}; // RULE11
            default: dec_out = '{op: OP_NONE, acc_b: 1'b0, mode: MODE_INH};
        endcase
    end

endmodule
`default_nettype wire

// *** rtl/logic_shift_alu.sv ***
// Combinational AND and arithmetic shift unit with flag generation.
`timescale 1ns/1ps
`default_nettype none
module logic_shift_alu
    import alu_ops_pkg::*;
(
    // Operation and operands.
    input wire op_kind_type op_in,
    input wire logic [15:0] opnd_in,
    input wire logic [7:0] mem_in,
    input wire nzvc_type flags_in,
    // Result and new flags.
    output var alu_out_type alu_out
);

    // Byte results sit in the low half; flags not touched pass through.
    always_comb begin
        logic [7:0] r8;
        r8 = 8'h00;
        alu_out.res = opnd_in;
        alu_out.f = flags_in;
        case (op_in)
            OP_AND: begin
                r8 = opnd_in[7:0] & mem_in; // RULE1
                alu_out.res = {8'h00, r8};
                alu_out.f.n = r8[7]; // RULE2
                alu_out.f.z = (r8 == 8'h00); // RULE2
                alu_out.f.v = 1'b0; // RULE2
            end
            OP_ASL: begin
                r8 = {opnd_in[6:0], 1'b0}; // RULE5
                alu_out.res = {8'h00, r8};
                alu_out.f.c = opnd_in[7]; // RULE6
                alu_out.f.n = r8[7]; // RULE6
                alu_out.f.z = (r8 == 8'h00); // RULE6
                alu_out.f.v = r8[7] ^ opnd_in[7]; // RULE6
            end
            OP_ASR: begin
                r8 = {opnd_in[7], opnd_in[7:1]}; // RULE12
                alu_out.res = {8'h00, r8};
                alu_out.f.c = opnd_in[0]; // RULE13
                alu_out.f.n = r8[7]; // RULE13
                alu_out.f.z = (r8 == 8'h00); // RULE13
                alu_out.f.v = r8[7] ^ opnd_in[0]; // RULE13
            end
            OP_SHIFT_LEFT_DOUBLE: begin
                alu_out.res = {opnd_in[14:0], 1'b0}; // RULE9
                alu_out.f.c = opnd_in[15]; // RULE10
                alu_out.f.n = opnd_in[14]; // RULE10
                alu_out.f.z = (opnd_in[14:0] == 15'h0000); // RULE10
                alu_out.f.v = opnd_in[14] ^ opnd_in[15]; // RULE10
            end
            default: begin
                alu_out.res = opnd_in;
                alu_out.f = flags_in;
            end
        endcase
    end

endmodule
`default_nettype wire

// *** rtl/logic_shift_core.sv ***
// Execution core for AND and arithmetic shifts with an Avalon-MM slave.
// Operation
// RULE1: AND accumulator with memory, write back.
// RULE2: AND sets N, Z; clears V.
// RULE3: First accumulator AND opcodes; indexed dummy read.
// RULE4: Second accumulator AND opcodes and cycle counts.
// RULE5: Byte shift left inserts zero.
// RULE6: Shift left flags: C old bit7, V=N^C.
// RULE7: Shift left opcodes; memory read-modify-write.
// RULE8: Cycle counts and final write cycle.
// RULE9: Double shift left inserts zero.
// RULE10: Double shift flags from bits 15.
// RULE11: Opcode 05, three cycles, dummy at FFFF.
// RULE12: Shift right keeps bit 7.
// RULE13: Shift right flags: C old bit0.
// RULE14: Shift right opcodes and cycle pattern.
// RULE15: First accumulator is upper half.
// RULE16: Indexed address is index plus offset.
`timescale 1ns/1ps
`default_nettype none
module logic_shift_core
    import alu_ops_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    // Avalon-MM register slave.
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // Program and data memory bus, one access per clock.
    output logic [15:0] mem_addr_out,
    output logic mem_rw_out,
    output logic mem_valid_out,
    output logic [7:0] mem_wdata_out,
    input wire logic [7:0] mem_rdata_in
);

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_FETCH = 4'b0001,
        ST_PREFIX = 4'b0010,
        ST_BYTE1 = 4'b0011,
        ST_BYTE2 = 4'b0100,
        ST_IDX_DUMMY = 4'b0101,
        ST_MEM_READ = 4'b0110,
        ST_RMW_DUMMY = 4'b0111,
        ST_MEM_WRITE = 4'b1000,
        ST_INH_DUMMY = 4'b1001
    } state_type;

    // Merges a write into an old word under the byte enables.
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_w,
                                                input logic [31:0] new_w,
                                                input logic [3:0] be);
        logic [31:0] m;
        m = old_w;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                m[8*i +: 8] = new_w[8*i +: 8];
            end
        end
        return m;
    endfunction

    state_type state_reg, state_next;
    decode_type dec_reg, dec_next, dec_now;
    logic [15:0] pc_reg, pc_next, ea_reg, ea_next;
    logic [15:0] x_reg, x_next, y_reg, y_next;
    logic [7:0] acc_a_reg, acc_a_next, acc_b_reg, acc_b_next;
    logic [7:0] condition_flags_register, flags_next;
    logic [7:0] wdata_reg, wdata_next;
    logic y_sel_reg, y_sel_next, run_reg, run_next;
    logic ack_reg, ack_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [15:0] double_byte_accumulator, alu_opnd, index_sel;
    logic [7:0] selected_byte_accumulator;
    logic commit, wr_ok, idle_wr;
    logic [31:0] ctrl_word, pc_word, index_word, acc_word;
    alu_out_type alu_res;

    // Double accumulator view, first accumulator in the upper half.
    assign double_byte_accumulator = {acc_a_reg, acc_b_reg}; // RULE15
    assign selected_byte_accumulator = dec_reg.acc_b ? acc_b_reg : acc_a_reg;
    assign index_sel = y_sel_reg ? y_reg : x_reg;

    // Operand: memory byte for memory shifts, else accumulator.
    always_comb begin
        if (dec_reg.op == OP_SHIFT_LEFT_DOUBLE) begin
            alu_opnd = double_byte_accumulator;
        end else if (dec_reg.op != OP_AND && dec_reg.mode != MODE_INH) begin
            alu_opnd = {8'h00, mem_rdata_in};
        end else begin
            alu_opnd = {8'h00, selected_byte_accumulator};
        end
    end

    op_decoder u_dec (
        .opcode_in(mem_rdata_in),
        .dec_out(dec_now)
    );

    logic_shift_alu u_alu (
        .op_in(dec_reg.op),
        .opnd_in(alu_opnd),
        .mem_in(mem_rdata_in),
        .flags_in(condition_flags_register[3:0]),
        .alu_out(alu_res)
    );

    // Bus address and direction follow the current cycle of the sequence.
    always_comb begin
        mem_valid_out = (state_reg != ST_IDLE);
        mem_rw_out = (state_reg != ST_MEM_WRITE); // RULE8
        mem_wdata_out = wdata_reg;
        case (state_reg)
            ST_IDX_DUMMY: mem_addr_out = DUMMY_ADDR; // RULE3
            ST_RMW_DUMMY: mem_addr_out = DUMMY_ADDR; // RULE8
            ST_INH_DUMMY: mem_addr_out = DUMMY_ADDR; // RULE11
            ST_MEM_READ: mem_addr_out = ea_reg;
            ST_MEM_WRITE: mem_addr_out = ea_reg; // RULE7
            default: mem_addr_out = pc_reg;
        endcase
    end

    // Register views seen by software.
    assign ctrl_word = {30'h0, state_reg != ST_IDLE, run_reg};
    assign pc_word = {16'h0000, pc_reg};
    assign index_word = {y_reg, x_reg};
    assign acc_word = {8'h00, condition_flags_register, acc_a_reg, acc_b_reg};
    assign wr_ok = avs_write_in && ack_reg;
    assign idle_wr = wr_ok && state_reg == ST_IDLE && !run_reg;

    // Sequencer, datapath registers and software writes.
    always_comb begin
        logic [31:0] mg;
        mg = 32'h0;
        state_next = state_reg;
        dec_next = dec_reg;
        pc_next = pc_reg;
        ea_next = ea_reg;
        x_next = x_reg;
        y_next = y_reg;
        acc_a_next = acc_a_reg;
        acc_b_next = acc_b_reg;
        flags_next = condition_flags_register;
        wdata_next = wdata_reg;
        y_sel_next = y_sel_reg;
        run_next = run_reg;
        commit = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (run_reg) begin
                    state_next = ST_FETCH;
                end
            end
            ST_FETCH: begin
                pc_next = pc_reg + 16'h0001;
                state_next = ST_BYTE1;
                y_sel_next = 1'b0;
                dec_next = dec_now;
                if (mem_rdata_in == OPC_PREFIX_Y) begin
                    y_sel_next = 1'b1; // RULE3
                    state_next = ST_PREFIX;
                end
            end
            ST_PREFIX: begin
                pc_next = pc_reg + 16'h0001;
                dec_next = dec_now;
                if (dec_now.mode != MODE_IDX) begin
                    // A prefix before a non-indexed opcode turns the pair into a no-op.
                    dec_next = '{op: OP_NONE, acc_b: 1'b0, mode: MODE_INH};
                end
                state_next = ST_BYTE1;
            end
            ST_BYTE1: begin
                case (dec_reg.mode)
                    MODE_INH: begin
                        if (dec_reg.op == OP_SHIFT_LEFT_DOUBLE) begin
                            state_next = ST_INH_DUMMY; // RULE11
                        end else begin
                            commit = 1'b1; // RULE8
                        end
                    end
                    MODE_IMM: begin
                        pc_next = pc_reg + 16'h0001;
                        commit = 1'b1; // RULE4
                    end
                    MODE_DIR: begin
                        pc_next = pc_reg + 16'h0001;
                        ea_next = {DIRECT_PAGE, mem_rdata_in};
                        state_next = ST_MEM_READ;
                    end
                    MODE_EXT: begin
                        pc_next = pc_reg + 16'h0001;
                        ea_next = {mem_rdata_in, 8'h00};
                        state_next = ST_BYTE2;
                    end
                    MODE_IDX: begin
                        pc_next = pc_reg + 16'h0001;
                        ea_next = index_sel + {8'h00, mem_rdata_in}; // RULE16
                        state_next = ST_IDX_DUMMY;
                    end
                    default: commit = 1'b1;
                endcase
            end
            ST_BYTE2: begin
                pc_next = pc_reg + 16'h0001;
                ea_next = {ea_reg[15:8], mem_rdata_in};
                state_next = ST_MEM_READ;
            end
            ST_IDX_DUMMY: state_next = ST_MEM_READ;
            ST_MEM_READ: begin
                if (dec_reg.op == OP_ASL || dec_reg.op == OP_ASR) begin
                    wdata_next = alu_res.res[7:0]; // RULE7
                    flags_next[3:0] = alu_res.f; // RULE14
                    state_next = ST_RMW_DUMMY;
                end else begin
                    commit = 1'b1; // RULE3
                end
            end
            ST_RMW_DUMMY: state_next = ST_MEM_WRITE;
            ST_MEM_WRITE: begin
                state_next = run_reg ? ST_FETCH : ST_IDLE;
            end
            ST_INH_DUMMY: commit = 1'b1; // RULE11
            default: state_next = ST_IDLE;
        endcase
        // Commit writes the result and flags, then ends the instruction.
        if (commit) begin
            state_next = run_reg ? ST_FETCH : ST_IDLE;
            if (dec_reg.op != OP_NONE) begin
                flags_next[3:0] = alu_res.f;
            end
            if (dec_reg.op == OP_SHIFT_LEFT_DOUBLE) begin
                {acc_a_next, acc_b_next} = alu_res.res; // RULE15
            end else if (dec_reg.op != OP_NONE && dec_reg.acc_b) begin
                acc_b_next = alu_res.res[7:0]; // RULE1
            end else if (dec_reg.op != OP_NONE) begin
                acc_a_next = alu_res.res[7:0]; // RULE1
            end
        end
        // Run may change at any time; state writes only while halted.
        if (wr_ok && avs_address_in[3:2] == OFS_CTRL[3:2]) begin
            mg = merge_bytes(ctrl_word, avs_writedata_in, avs_byteenable_in);
            run_next = mg[CTRL_RUN];
        end
        if (idle_wr && avs_address_in[3:2] == OFS_PC[3:2]) begin
            mg = merge_bytes(pc_word, avs_writedata_in, avs_byteenable_in);
            pc_next = mg[15:0];
        end
        if (idle_wr && avs_address_in[3:2] == OFS_INDEX[3:2]) begin
            mg = merge_bytes(index_word, avs_writedata_in, avs_byteenable_in);
            {y_next, x_next} = mg;
        end
        if (idle_wr && avs_address_in[3:2] == OFS_ACC[3:2]) begin
            mg = merge_bytes(acc_word, avs_writedata_in, avs_byteenable_in);
            {flags_next, acc_a_next, acc_b_next} = mg[23:0];
        end
    end

    // Core registers.
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_reg <= ST_IDLE;
            dec_reg <= '{op: OP_NONE, acc_b: 1'b0, mode: MODE_INH};
            pc_reg <= PC_RESET;
            ea_reg <= PC_RESET;
            x_reg <= INDEX_RESET;
            y_reg <= INDEX_RESET;
            acc_a_reg <= ACC_RESET;
            acc_b_reg <= ACC_RESET;
            condition_flags_register <= FLAGS_RESET;
            wdata_reg <= ACC_RESET;
            y_sel_reg <= 1'b0;
            run_reg <= CTRL_RUN_RESET;
        end else begin
            state_reg <= state_next;
            dec_reg <= dec_next;
            pc_reg <= pc_next;
            ea_reg <= ea_next;
            x_reg <= x_next;
            y_reg <= y_next;
            acc_a_reg <= acc_a_next;
            acc_b_reg <= acc_b_next;
            condition_flags_register <= flags_next;
            wdata_reg <= wdata_next;
            y_sel_reg <= y_sel_next;
            run_reg <= run_next;
        end
    end

    // Slave answers one cycle after a request; unmapped reads give zero.
    assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !ack_reg;
    assign avs_readdata_out = rdata_reg;
    always_comb begin
        ack_next = (avs_read_in || avs_write_in) && !ack_reg;
        rdata_next = rdata_reg;
        if (avs_read_in && !ack_reg) begin
            case (avs_address_in[3:2])
                OFS_CTRL[3:2]: rdata_next = ctrl_word;
                OFS_PC[3:2]: rdata_next = pc_word;
                OFS_INDEX[3:2]: rdata_next = index_word;
                OFS_ACC[3:2]: rdata_next = acc_word;
                default: rdata_next = 32'h0000_0000;
            endcase
        end
    end

    // Slave handshake registers.
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= ack_next;
            rdata_reg <= rdata_next;
        end
    end

    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_b_in);

    logic at_fetch, boundary;
    assign at_fetch = state_reg == ST_FETCH;
    assign boundary = state_reg == ST_FETCH || state_reg == ST_IDLE;

    and_writeback_a: assert property (commit && dec_reg.op == OP_AND // RULE1
        |=> selected_byte_accumulator == $past(alu_opnd[7:0] & mem_rdata_in))
        else $error("AND result not written back.");
    and_flags_a: assert property (commit && dec_reg.op == OP_AND // RULE2
        |=> !condition_flags_register[FLAG_V] &&
            condition_flags_register[FLAG_Z] == (selected_byte_accumulator == 8'h00))
        else $error("AND flags wrong.");
    imm_cycles_a: assert property (at_fetch && mem_rdata_in == OPC_AND_A_IMM // RULE3
        |-> ##2 boundary) else $error("AND immediate not two cycles.");
    ext_cycles_a: assert property (at_fetch && mem_rdata_in == OPC_AND_B_EXT // RULE4
        |-> ##1 !boundary [*3] ##1 boundary) else $error("AND extended length.");
    rmw_write_a: assert property (at_fetch && mem_rdata_in == OPC_ASL_EXT // RULE8
        |-> ##5 (!mem_rw_out && mem_addr_out == $past(mem_addr_out, 2))
        ##1 boundary) else $error("Memory shift write cycle wrong.");
    idx_dummy_a: assert property (state_reg == ST_IDX_DUMMY // RULE3
        |-> mem_addr_out == DUMMY_ADDR && mem_rw_out)
        else $error("Indexed dummy cycle not at FFFF.");
    double_cycles_a: assert property (at_fetch && mem_rdata_in == OPC_SHIFT_LEFT_DOUBLE // RULE11
        |-> ##1 mem_addr_out == $past(mem_addr_out) + 16'h0001
        ##1 mem_addr_out == DUMMY_ADDR ##1 boundary)
        else $error("Double shift sequence wrong.");
    double_shift_a: assert property (state_reg == ST_INH_DUMMY // RULE10
        |=> double_byte_accumulator[15:1] == $past(double_byte_accumulator[14:0])
        && !double_byte_accumulator[0]
        && condition_flags_register[FLAG_C] == $past(double_byte_accumulator[15]))
        else $error("Double shift result wrong.");
    shift_v_a: assert property (commit && dec_reg.op inside {OP_ASL, OP_ASR} // RULE6
        |=> condition_flags_register[FLAG_V] == (condition_flags_register[FLAG_N]
            ^ condition_flags_register[FLAG_C])) else $error("Shift V wrong.");
    asr_sign_a: assert property (state_reg == ST_MEM_READ && dec_reg.op == OP_ASR // RULE12
        |=> wdata_reg[7] == $past(mem_rdata_in[7]) && condition_flags_register[FLAG_C]
            == $past(mem_rdata_in[0])) else $error("Shift right sign lost.");
    idx_addr_a: assert property (state_reg == ST_BYTE1 && dec_reg.mode == MODE_IDX // RULE16
        |=> ea_reg == $past(index_sel) + {8'h00, $past(mem_rdata_in)})
        else $error("Indexed address wrong.");

    and_y_c: cover property (state_reg == ST_PREFIX ##3 commit && dec_reg.op == OP_AND);
    asr_mem_c: cover property (state_reg == ST_MEM_WRITE && dec_reg.op == OP_ASR);
    shift_left_double_c: cover property (state_reg == ST_INH_DUMMY);
    reg_write_c: cover property (idle_wr);

endmodule
`default_nettype wire

// *** verif/prog_mem_model.sv ***
// Program and data memory model with a combinational read port.
`timescale 1ns/1ps
`default_nettype none
module prog_mem_model (
    // Clock and processor bus.
    input wire logic clk_in,
    input wire logic [15:0] addr_in,
    input wire logic rw_in,
    input wire logic valid_in,
    input wire logic [7:0] wdata_in,
    output logic [7:0] rdata_out
);
    logic [7:0] mem [0:65535];
    logic [7:0] last;
    // Memory starts cleared so unknown opcodes act as no-ops.
    initial begin
        for (int i = 0; i < 65536; i++) mem[i] = 8'h00;
        last = 8'h00;
    end
    // An idle bus shows the inverse of the last byte, never stale data.
    assign rdata_out = (valid_in && rw_in) ? mem[addr_in] : ~last;
    // Writes land at the edge that ends the write cycle.
    always @(posedge clk_in) begin
        last <= rdata_out;
        if (valid_in && !rw_in)
            mem[addr_in] <= wdata_in;
    end
endmodule
`default_nettype wire

// *** verif/tb_top.sv ***
// Testbench running one instruction at a time and checking its effects.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    typedef struct packed {
        logic [23:0] code;
        logic [15:0] ma;
        logic [7:0] md;
        logic [23:0] acc0;
        logic [23:0] acc1;
        logic [3:0] cyc;
        logic [7:0] mres;
    } test_type;
    // Opcode bytes, operand cell, {flags,A,B} before and after, cycles.
    test_type tests [11] = '{
        '{24'h84AA00, 16'h0020, 8'h00, 24'h00F03C, 24'h08A03C, 4'h2, 8'h00},
        '{24'hD42000, 16'h0020, 8'h0F, 24'h02003C, 24'h00000C, 4'h3, 8'h0F},
        '{24'h050000, 16'h0020, 8'h00, 24'h008001, 24'h030002, 4'h3, 8'h00},
        '{24'h580000, 16'h0020, 8'h00, 24'h001180, 24'h071100, 4'h2, 8'h00},
        '{24'h570000, 16'h0020, 8'h00, 24'h002281, 24'h0922C0, 4'h2, 8'h00},
        '{24'h780200, 16'h0200, 8'h41, 24'h001122, 24'h0A1122, 4'h6, 8'h82},
        '{24'h186710, 16'h0410, 8'h02, 24'h0F1122, 24'h001122, 4'h7, 8'h01},
        '{24'hA40500, 16'h0305, 8'h55, 24'h00FF00, 24'h005500, 4'h4, 8'h55},
        '{24'hF40210, 16'h0210, 8'h3C, 24'h00F0FF, 24'h00F03C, 4'h4, 8'h3C},
        '{24'h480000, 16'h0020, 8'h00, 24'h04C000, 24'h098000, 4'h2, 8'h00},
        '{24'h470000, 16'h0020, 8'h00, 24'h000100, 24'h070000, 4'h2, 8'h00}};
    logic ref_clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [15:0] mem_addr;
    logic mem_rw, mem_valid, clr;
    logic [7:0] mem_wdata, mem_rdata, ncyc;
    int n_errors = 0;
    int total_checks = 0;
    logic hold = 1'b0;
    always #2.5 ref_clk_in = ~ref_clk_in;
    // Counts bus cycles of the instruction under test.
    always @(posedge ref_clk_in) ncyc <= clr ? 8'h00 : ncyc + {7'h00, mem_valid};
    logic_shift_core dut (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
        .avs_address_in(avs_address), .avs_read_in(avs_read),
        .avs_write_in(avs_write), .avs_writedata_in(avs_writedata),
        .avs_byteenable_in(4'hF), .avs_readdata_out(avs_readdata),
        .avs_waitrequest_out(avs_waitrequest), .mem_addr_out(mem_addr),
        .mem_rw_out(mem_rw), .mem_valid_out(mem_valid),
        .mem_wdata_out(mem_wdata), .mem_rdata_in(mem_rdata));
    prog_mem_model mdl (.clk_in(ref_clk_in), .addr_in(mem_addr),
        .rw_in(mem_rw), .valid_in(mem_valid), .wdata_in(mem_wdata),
        .rdata_out(mem_rdata));
    // Prints the counts and the verdict, then stops the run.
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Compares a seen value with the expected one.
    task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One Avalon access, held until waitrequest is sampled low.
    // With hold set the request stays up for a back-to-back call.
    task automatic bus(logic w, logic [3:0] a, logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        do begin
            @(posedge ref_clk_in);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        if (n >= 50) begin
            n_errors++;
            give_verdict();
        end else if (!hold) begin
            avs_read <= 1'b0;
            avs_write <= 1'b0;
            @(posedge ref_clk_in);
        end
    endtask
    // Loads each instruction, runs it alone and checks the outcome.
    initial begin
        logic [31:0] q;
        int n;
        clr = 1'b1;
        repeat (16) @(posedge ref_clk_in);
        rst_b_in <= 1'b1;
        @(posedge ref_clk_in);
        bus(1'b1, 4'h8, 32'h04000300, q);
        foreach (tests[i]) begin
            {mdl.mem[16'h0100], mdl.mem[16'h0101]} = tests[i].code[23:8];
            mdl.mem[16'h0102] = tests[i].code[7:0];
            mdl.mem[tests[i].ma] = tests[i].md;
            clr <= 1'b1;
            bus(1'b1, 4'h4, 32'h00000100, q);
            bus(1'b1, 4'hC, {8'h00, tests[i].acc0}, q);
            clr <= 1'b0;
            // Stop follows run back to back, so one instruction runs.
            hold = 1'b1;
            bus(1'b1, 4'h0, 32'h00000001, q);
            hold = 1'b0;
            bus(1'b1, 4'h0, 32'h00000000, q);
            n = 0;
            q = 32'h00000002;
            while (q[1] !== 1'b0 && n < 50) begin
                bus(1'b0, 4'h0, 32'h00000000, q);
                n++;
            end
            chk("ctrl", q, 32'h00000000);
            bus(1'b0, 4'hC, 32'h00000000, q);
            chk("acc", q, {8'h00, tests[i].acc1});
            chk("cycles", {24'h000000, ncyc}, {28'h0, tests[i].cyc});
            chk("mem", {24'h000000, mdl.mem[tests[i].ma]}, {24'h000000, tests[i].mres});
            $display("test %0d done", i);
        end
        give_verdict();
    end
endmodule
`default_nettype wire
